// *** omc_consts.vh ***
// constants for the operating mode control block
`ifndef OMC_CONSTS_VH
`define OMC_CONSTS_VH
// register offset of the mode control register
`define OMC_MODE_OFFSET 16'h000b
// field positions inside the mode control register
`define OMC_BIT_SPECIAL_LOW 7
`define OMC_BIT_MODE_B 6
`define OMC_BIT_MODE_A 5
`define OMC_BIT_STRETCH 4
`define OMC_BIT_VISIBLE 3
`define OMC_BIT_BUS_STOP 2
`define OMC_BIT_EMULATE_E 0
// mode pin codes, written as {mode_pin_b, mode_pin_a}
`define OMC_PINS_SINGLE 2'h0
`define OMC_PINS_NARROW 2'h1
`define OMC_PINS_PERIPH 2'h2
`define OMC_PINS_WIDE 2'h3
// reset values of the configuration fields
`define OMC_RST_STRETCH 1'h1
`define OMC_RST_BUS_STOP 1'h0
// debug region bounds
`define OMC_DBG_REGS_BASE 16'hff00
`define OMC_DBG_REGS_TOP 16'hff06
`define OMC_DBG_ROM_BASE 16'hff20
`endif

// *** omc_mode_ctrl.v ***
// operating mode latch, decode, mode control register and map gating
`timescale 1ns/10ps
`include "omc_consts.vh"

//Contract
//- latch debug pin and both mode pins at reset release
//- decode three bits into eight modes; normal 10 forced peripheral
//- normal modes lock protected bits after allowed writes; special allows more
//- special single chip: debug enabled and active right after reset
//- single chip: no external bus, ports A and B general I/O
//- expanded wide: ports A and B form 16-bit multiplexed bus
//- expanded narrow: 8-bit data on port A, high byte then low
//- peripheral mode: core held off; entered or left only by reset
//- other modes: debug must be enabled before it goes active
//- enabled debug activates by serial command or halt instruction
//- active debug maps debug ROM and registers at top, replacing vectors
//- active debug hides user memory in top 256 bytes
//- mode control register absent from map in peripheral mode
//- special select readable; written only in special, first write ignored
//- mode bits: once in normal, anytime special except first write
//- refuse mode writes choosing peripheral or reserved modes
//- expanded and peripheral: port A/B data and direction unmapped
//- port E registers unmapped in peripheral, or expanded with emulate bit
//- unimplemented reads return undefined value; here zero
//- stretch enable held one in every expanded mode
//- single chip keeps port E registers mapped regardless of emulate bit
module omc_mode_ctrl (
	input wire clk, // system clock, 40 MHz
	input wire rst_n, // asynchronous reset, active low
	input wire debug_pin, // debug pin level, mode strap
	input wire mode_pin_b, // mode strap b
	input wire mode_pin_a, // mode strap a
	input wire [15:0] reg_addr, // register address
	input wire [7:0] reg_wdata, // register write data
	input wire reg_wr, // write strobe
	input wire reg_rd, // read strobe
	output reg [7:0] reg_rdata, // read data, one cycle after strobe
	input wire debug_enable_cmd, // serial enable command seen
	input wire debug_activate_cmd, // serial activate command seen
	input wire halt_to_debug_instr, // core executed halt-to-debug
	input wire debug_exit, // debug firmware returns to user code
	input wire [15:0] cpu_addr, // core address for map decode
	output reg special_select_low, // 1 normal, 0 special
	output reg [1:0] mode_bits, // current {b,a} mode bits
	output reg stretch_clock_enable, // clock stretch enable
	output reg internal_bus_visible, // internal visibility
	output reg bus_stop_in_wait, // shut external bus in wait
	output reg emulate_port_e, // emulate port E externally
	output reg ports_ab_gpio, // ports A and B general purpose
	output reg ext_bus_wide, // 16-bit multiplexed external bus
	output reg ext_bus_narrow, // 8-bit multiplexed external bus
	output reg core_hold, // core held inactive
	output reg background_debug_enabled, // debug firmware enabled
	output reg background_debug_active, // debug firmware active
	output reg ports_ab_regs_mapped, // port A/B and direction regs in map
	output reg port_e_regs_mapped, // port_e_data and port_e_direction in map
	output reg mode_reg_mapped, // mode control register in map
	output reg debug_rom_sel, // core address hits debug ROM
	output reg debug_regs_sel, // core address hits debug registers
	output reg user_top_blocked // core address in hidden user top page
);

	// one-hot startup states: first edge after release captures straps
	localparam ST_CAPTURE = 2'b01;
	localparam ST_RUN = 2'b10;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg spec_low_ff;
	reg [1:0] mbits_ff;
	reg stretch_clock_enable_ff;
	reg internal_bus_visible_ff;
	reg bus_stop_in_wait_ff;
	reg eme_ff;
	reg first_wr_done_ff;
	reg mbits_wr_once_ff;
	reg stretch_clock_enable_wr_once_ff;
	reg internal_bus_visible_wr_once_ff;
	reg eme_wr_once_ff;
	reg dbg_en_ff;
	reg dbg_act_ff;
	reg [7:0] nxt_rdata;
	// next values of the registered outputs
	reg nxt_special_select_low;
	reg [1:0] nxt_mode_bits;
	reg nxt_stretch_clock_enable;
	reg nxt_internal_bus_visible;
	reg nxt_bus_stop_in_wait;
	reg nxt_emulate_port_e;
	reg nxt_ports_ab_gpio;
	reg nxt_ext_bus_wide;
	reg nxt_ext_bus_narrow;
	reg nxt_core_hold;
	reg nxt_background_debug_enabled;
	reg nxt_background_debug_active;
	reg nxt_ports_ab_regs_mapped;
	reg nxt_port_e_regs_mapped;
	reg nxt_mode_reg_mapped;
	reg nxt_debug_rom_sel;
	reg nxt_debug_regs_sel;
	reg nxt_user_top_blocked;

	// true when {b,a} selects single chip
	function is_single;
		input [1:0] code;
		begin
			is_single = (code == `OMC_PINS_SINGLE);
		end
	endfunction

	// true when {b,a} selects either expanded width
	function is_expanded;
		input [1:0] code;
		begin
			is_expanded = (code == `OMC_PINS_NARROW) || (code == `OMC_PINS_WIDE);
		end
	endfunction

	// write permission shared by the mode, visibility and emulate fields
	// special modes drop only the first write; normal modes take one
	function may_write;
		input spec;
		input counted;
		input used_once;
		begin
			may_write = counted || (!spec && !used_once);
		end
	endfunction

	// true when a core address lies inside [lo, hi]
	function in_window;
		input [15:0] addr;
		input [15:0] lo;
		input [15:0] hi;
		begin
			in_window = (addr >= lo) && (addr <= hi);
		end
	endfunction

	wire mode_hit = (reg_addr == `OMC_MODE_OFFSET);
	wire periph = (mbits_ff == `OMC_PINS_PERIPH);
	wire mode_vis = mode_hit && !periph;
	wire mode_wr = reg_wr && mode_vis && (state_ff == ST_RUN);
	wire special = !spec_low_ff;
	// first write in special modes is swallowed by every field except stretch
	wire special_counted = special && first_wr_done_ff;
	wire [1:0] wr_mbits = {reg_wdata[`OMC_BIT_MODE_B], reg_wdata[`OMC_BIT_MODE_A]};
	wire wr_spec_low = reg_wdata[`OMC_BIT_SPECIAL_LOW];
	// target mode after write must not be peripheral
	wire wr_mode_ok = (wr_mbits != `OMC_PINS_PERIPH);
	wire cur_single = is_single(mbits_ff);
	wire cur_exp = is_expanded(mbits_ff);
	// write permission per field for the current mode
	// stretch is open in every special write, so it needs no such wire
	wire mbits_may_wr = may_write(special, special_counted, mbits_wr_once_ff);
	wire internal_bus_visible_may_wr = may_write(special, special_counted, internal_bus_visible_wr_once_ff);
	wire eme_may_wr = may_write(special, special_counted, eme_wr_once_ff);
	// straps that ask for special single chip
	wire ssc_straps = !debug_pin && ({mode_pin_b, mode_pin_a} == `OMC_PINS_SINGLE);

	// next state of the startup sequence
	always @* begin
		case (state_ff)
			ST_CAPTURE: nxt_state = ST_RUN;
			ST_RUN: nxt_state = ST_RUN;
			default: nxt_state = ST_RUN;
		endcase
	end

	// startup sequence register
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			state_ff <= ST_CAPTURE;
		else
			state_ff <= nxt_state;
	end

	// straps are sampled by a clocked process, never through the async reset
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			spec_low_ff <= 1'h1;
			mbits_ff <= `OMC_PINS_SINGLE;
		end else if (state_ff == ST_CAPTURE) begin
			spec_low_ff <= debug_pin;
			// reserved normal code lands on peripheral decode
			mbits_ff <= {mode_pin_b, mode_pin_a};
		end else if (mode_wr) begin
			if (special_counted)
				spec_low_ff <= wr_spec_low;
			if (!periph && wr_mode_ok && mbits_may_wr)
				mbits_ff <= wr_mbits;
		end
	end

	// at capture visibility and emulate follow the debug strap; stretch and bus stop take fixed values
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stretch_clock_enable_ff <= `OMC_RST_STRETCH;
			internal_bus_visible_ff <= 1'h0;
			bus_stop_in_wait_ff <= `OMC_RST_BUS_STOP;
			eme_ff <= 1'h0;
		end else if (state_ff == ST_CAPTURE) begin
			stretch_clock_enable_ff <= `OMC_RST_STRETCH;
			internal_bus_visible_ff <= !debug_pin;
			eme_ff <= !debug_pin;
			bus_stop_in_wait_ff <= `OMC_RST_BUS_STOP;
		end else if (mode_wr) begin
			// protected bits: once in normal, wider in special
			if (special || !stretch_clock_enable_wr_once_ff)
				stretch_clock_enable_ff <= reg_wdata[`OMC_BIT_STRETCH];
			// visibility and emulate drop the first special write
			if (internal_bus_visible_may_wr)
				internal_bus_visible_ff <= reg_wdata[`OMC_BIT_VISIBLE];
			if (eme_may_wr)
				eme_ff <= reg_wdata[`OMC_BIT_EMULATE_E];
			// bus stop: anytime in normal, never in special
			if (!special)
				bus_stop_in_wait_ff <= reg_wdata[`OMC_BIT_BUS_STOP];
		end
	end

	// write bookkeeping; a refused normal write still uses up its one chance
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			first_wr_done_ff <= 1'h0;
			mbits_wr_once_ff <= 1'h0;
			stretch_clock_enable_wr_once_ff <= 1'h0;
			internal_bus_visible_wr_once_ff <= 1'h0;
			eme_wr_once_ff <= 1'h0;
		end else if (mode_wr) begin
			first_wr_done_ff <= 1'h1;
			// one normal write closes every write-once field together
			if (!special) begin
				mbits_wr_once_ff <= 1'h1;
				stretch_clock_enable_wr_once_ff <= 1'h1;
				internal_bus_visible_wr_once_ff <= 1'h1;
				eme_wr_once_ff <= 1'h1;
			end
		end
	end

	// debug enable; commands in the capture cycle are ignored
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			dbg_en_ff <= 1'h0;
		else if (state_ff == ST_CAPTURE)
			dbg_en_ff <= ssc_straps;
		else if (debug_enable_cmd)
			dbg_en_ff <= 1'h1;
	end

	// debug activation; set wins over exit in the same cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			dbg_act_ff <= 1'h0;
		else if (state_ff == ST_CAPTURE)
			// special single chip straps: active straight out of reset, no command needed
			dbg_act_ff <= ssc_straps;
		else if (dbg_en_ff && (debug_activate_cmd || halt_to_debug_instr))
			dbg_act_ff <= 1'h1;
		else if (debug_exit)
			dbg_act_ff <= 1'h0;
	end

	// read mux; unmapped and hidden addresses read zero
	always @* begin
		nxt_rdata = 8'h00;
		if (reg_rd && mode_vis) begin
			nxt_rdata[`OMC_BIT_SPECIAL_LOW] = spec_low_ff;
			nxt_rdata[`OMC_BIT_MODE_B] = mbits_ff[1];
			nxt_rdata[`OMC_BIT_MODE_A] = mbits_ff[0];
			nxt_rdata[`OMC_BIT_STRETCH] = stretch_clock_enable_ff || cur_exp;
			nxt_rdata[`OMC_BIT_VISIBLE] = internal_bus_visible_ff;
			nxt_rdata[`OMC_BIT_BUS_STOP] = bus_stop_in_wait_ff;
			nxt_rdata[`OMC_BIT_EMULATE_E] = eme_ff;
		end
	end

	// next values of the mode outputs and map gating
	always @* begin
		// plain copies of the stored select and mode fields
		nxt_special_select_low = spec_low_ff;
		nxt_mode_bits = mbits_ff;
		nxt_stretch_clock_enable = stretch_clock_enable_ff || cur_exp;
		// no visibility without an external bus to show it on
		nxt_internal_bus_visible = internal_bus_visible_ff && !cur_single;
		nxt_bus_stop_in_wait = bus_stop_in_wait_ff;
		nxt_emulate_port_e = eme_ff;
		// single chip: ports general purpose, no bus
		nxt_ports_ab_gpio = cur_single;
		// wide bus on ports A and B
		// peripheral mode also runs both ports as address/data
		nxt_ext_bus_wide = (mbits_ff == `OMC_PINS_WIDE) || periph;
		// narrow bus, byte pairs high then low
		nxt_ext_bus_narrow = (mbits_ff == `OMC_PINS_NARROW);
		// core inactive in peripheral mode
		// also held through the strap capture cycle
		nxt_core_hold = periph || (state_ff == ST_CAPTURE);
		// debug state, shown one cycle behind its flops
		nxt_background_debug_enabled = dbg_en_ff;
		nxt_background_debug_active = dbg_act_ff;
		// port A/B registers only in single chip
		nxt_ports_ab_regs_mapped = cur_single;
		// port E unmapped in peripheral or emulated expanded
		// single chip keeps port E mapped
		nxt_port_e_regs_mapped = cur_single || (cur_exp && !eme_ff);
		// mode register leaves the map in peripheral mode
		nxt_mode_reg_mapped = !periph;
		// debug ROM and registers at top while active
		nxt_debug_rom_sel = dbg_act_ff && (cpu_addr >= `OMC_DBG_ROM_BASE);
		nxt_debug_regs_sel = dbg_act_ff && in_window(cpu_addr, `OMC_DBG_REGS_BASE, `OMC_DBG_REGS_TOP);
		// hide user top page while active
		nxt_user_top_blocked = dbg_act_ff && (cpu_addr >= `OMC_DBG_REGS_BASE);
	end

	// registered outputs, so every pin comes straight from a flop
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// held core in single chip, every map open
			reg_rdata <= 8'h00;
			special_select_low <= 1'h1;
			mode_bits <= 2'h0;
			stretch_clock_enable <= 1'h1;
			internal_bus_visible <= 1'h0;
			bus_stop_in_wait <= 1'h0;
			emulate_port_e <= 1'h0;
			ports_ab_gpio <= 1'h1;
			ext_bus_wide <= 1'h0;
			ext_bus_narrow <= 1'h0;
			core_hold <= 1'h1;
			background_debug_enabled <= 1'h0;
			background_debug_active <= 1'h0;
			ports_ab_regs_mapped <= 1'h1;
			port_e_regs_mapped <= 1'h1;
			mode_reg_mapped <= 1'h1;
			debug_rom_sel <= 1'h0;
			debug_regs_sel <= 1'h0;
			user_top_blocked <= 1'h0;
		end else begin
			reg_rdata <= nxt_rdata;
			special_select_low <= nxt_special_select_low;
			mode_bits <= nxt_mode_bits;
			stretch_clock_enable <= nxt_stretch_clock_enable;
			internal_bus_visible <= nxt_internal_bus_visible;
			bus_stop_in_wait <= nxt_bus_stop_in_wait;
			emulate_port_e <= nxt_emulate_port_e;
			ports_ab_gpio <= nxt_ports_ab_gpio;
			ext_bus_wide <= nxt_ext_bus_wide;
			ext_bus_narrow <= nxt_ext_bus_narrow;
			core_hold <= nxt_core_hold;
			background_debug_enabled <= nxt_background_debug_enabled;
			background_debug_active <= nxt_background_debug_active;
			ports_ab_regs_mapped <= nxt_ports_ab_regs_mapped;
			port_e_regs_mapped <= nxt_port_e_regs_mapped;
			mode_reg_mapped <= nxt_mode_reg_mapped;
			debug_rom_sel <= nxt_debug_rom_sel;
			debug_regs_sel <= nxt_debug_regs_sel;
			user_top_blocked <= nxt_user_top_blocked;
		end
	end

endmodule // omc_mode_ctrl

// *** omc_host_model.sv ***
// far side: reset-time mode straps and serial debug host
`timescale 1ns/10ps
module omc_host_model (
	input logic clk, // system clock
	input logic [2:0] strap, // {debug, b, a} levels
	input logic [1:0] cmd, // 1 enable, 2 activate
	output logic debug_pin, // debug pin strap
	output logic mode_pin_b, // mode strap b
	output logic mode_pin_a, // mode strap a
	output logic debug_enable_cmd = 1'h0, // enable seen
	output logic debug_activate_cmd = 1'h0 // activate seen
);
	// straps stay put across reset and after it
	assign {debug_pin, mode_pin_b, mode_pin_a} = strap;
	// no commands sent in peripheral mode
	always @(posedge clk) begin
		debug_enable_cmd <= cmd[0] && strap[1:0] != 2'h2;
		debug_activate_cmd <= cmd[1] && strap[1:0] != 2'h2;
	end
endmodule // omc_host_model

// *** omc_mode_ctrl_sva.sv ***
// concurrent checks on the operating mode control ports
`timescale 1ns/10ps
module omc_mode_ctrl_sva (
	input logic clk, // clock
	input logic rst_n, // reset, active low
	input logic debug_pin, // strap
	input logic mode_pin_b, // strap
	input logic mode_pin_a, // strap
	input logic [1:0] mode_bits, // mode
	input logic emulate_port_e, // eme
	input logic stretch_clock_enable, // stretch
	input logic background_debug_active, // debug on
	input logic ports_ab_gpio, // gpio
	input logic ext_bus_wide, // wide bus
	input logic ext_bus_narrow, // narrow bus
	input logic core_hold, // core off
	input logic ports_ab_regs_mapped, // a/b map
	input logic port_e_regs_mapped, // e map
	input logic mode_reg_mapped, // mode map
	input logic debug_rom_sel, // rom hit
	input logic debug_regs_sel, // regs hit
	input logic user_top_blocked // top hidden
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// release of reset, and release with special single chip straps
	sequence rel_s;
		$rose(rst_n);
	endsequence
	sequence ssc_rel_s;
		rel_s ##0 (!debug_pin && !mode_pin_b && !mode_pin_a);
	endsequence
	// peripheral mode as seen on the outputs
	sequence peri_s;
		core_hold && mode_bits == 2'h2;
	endsequence
	// straps land two edges after release
	strap_capture_a: assert property (rel_s |-> ##2 mode_bits == {mode_pin_b, mode_pin_a} && emulate_port_e == !debug_pin)
		else $error("strap capture wrong");
	// debug live straight out of reset
	ssc_debug_a: assert property (ssc_rel_s |-> ##2 background_debug_active) else $error("debug not live");
	gpio_no_bus_a: assert property (ports_ab_gpio |-> !ext_bus_wide && !ext_bus_narrow) else $error("bus in gpio");
	// wide bus drops port a/b registers
	wide_unmap_a: assert property (ext_bus_wide |-> !ports_ab_regs_mapped) else $error("a/b still mapped");
	stretch_exp_a: assert property ((ext_bus_wide || ext_bus_narrow) |-> stretch_clock_enable) else $error("stretch off");
	// peripheral drops mode and port e registers
	peri_unmap_a: assert property (peri_s |-> !mode_reg_mapped && !port_e_regs_mapped) else $error("peri map");
	peri_stay_a: assert property (peri_s |=> mode_bits == 2'h2 && core_hold) else $error("left peripheral");
	// single chip keeps port e registers
	sc_port_e_a: assert property (ports_ab_gpio |-> port_e_regs_mapped) else $error("port e unmapped");
	// rom hit lies in hidden top page
	rom_top_a: assert property (debug_rom_sel |-> user_top_blocked && !debug_regs_sel) else $error("rom select");
endmodule // omc_mode_ctrl_sva
bind omc_mode_ctrl omc_mode_ctrl_sva u_sva (.*);

// *** tb_top.sv ***
// self-checking bench for the operating mode control block
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_top;
	logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, halt_to_debug_instr = 0, debug_exit = 0;
	logic [2:0] strap = 0;
	logic [1:0] cmd = 0;
	logic [15:0] reg_addr = 0, cpu_addr = 0;
	logic [7:0] reg_wdata = 0;
	wire [7:0] reg_rdata;
	wire [1:0] mode_bits;
	wire debug_pin, mode_pin_b, mode_pin_a, debug_enable_cmd, debug_activate_cmd, special_select_low;
	wire stretch_clock_enable, internal_bus_visible, bus_stop_in_wait, emulate_port_e, ports_ab_gpio;
	wire ext_bus_wide, ext_bus_narrow, core_hold, background_debug_enabled, background_debug_active;
	wire ports_ab_regs_mapped, port_e_regs_mapped, mode_reg_mapped, debug_rom_sel, debug_regs_sel, user_top_blocked;
	wire [11:0] outs = {mode_bits, ports_ab_gpio, ext_bus_wide, ext_bus_narrow, core_hold, ports_ab_regs_mapped,
		port_e_regs_mapped, mode_reg_mapped, background_debug_active, emulate_port_e, stretch_clock_enable};
	// rows: strap code, then expected outs after release
	logic [14:0] rows [8] = '{15'h023f, 15'h148b, 15'h2943, 15'h3d0b, 15'h4239, 15'h5499, 15'h6941, 15'h7d19};
	int n_fail = 0, checked = 0, cyc = 0;
	omc_mode_ctrl u_dut (.*);
	omc_host_model u_host (.*);
	always #12.5 clk = ~clk;
	task automatic end_sim;
		if (n_fail == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// hang guard, far above the under two hundred cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			end_sim;
		end
	end
	task automatic rst(input logic [2:0] c);
		@(posedge clk);
		rst_n <= 0;
		strap <= c;
		repeat (4) @(posedge clk);
		rst_n <= 1;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// write lands on outputs two edges after the strobe edge
	task automatic wr(input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= 16'h000b;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 0;
		#1;
		`CHK("read data", e, reg_rdata)
	endtask
	// k = {exit, halt, activate, enable}
	task automatic ev(input logic [3:0] k);
		@(posedge clk);
		cmd <= k[1:0];
		halt_to_debug_instr <= k[2];
		debug_exit <= k[3];
		@(posedge clk);
		cmd <= 0;
		halt_to_debug_instr <= 0;
		debug_exit <= 0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic ad(input logic [15:0] a, input logic [2:0] e);
		@(posedge clk);
		cpu_addr <= a;
		repeat (2) @(posedge clk);
		#1;
		`CHK("map select", e, {debug_rom_sel, debug_regs_sel, user_top_blocked})
	endtask
	initial begin
		// every strap code after reset
		foreach (rows[i]) begin
			rst(rows[i][14:12]);
			`CHK("mode outputs", rows[i][11:0], outs)
		end
		rst(3'h4);
		ev(4'h2);
		`CHK("active unenabled", 1'h0, background_debug_active)
		ev(4'h1);
		ev(4'h2);
		`CHK("active", 2'h3, {background_debug_enabled, background_debug_active})
		ad(16'hff20, 3'h5);
		ad(16'hff06, 3'h3);
		ad(16'hff10, 3'h1);
		ad(16'hfe00, 3'h0);
		ev(4'h8);
		ad(16'hff20, 3'h0);
		ev(4'h4);
		`CHK("halt active", 1'h1, background_debug_active)
		// normal narrow: mode bits written once, bus stop any time
		rst(3'h5);
		wr(8'hf4);
		`CHK("mode wide", 4'hf, {mode_bits, ext_bus_wide, bus_stop_in_wait})
		rd(16'h000b, 8'hf4);
		wr(8'h30);
		rd(16'h000b, 8'hf0);
		rd(16'h0012, 8'h00);
		// special single chip: first write dropped, peripheral refused
		rst(3'h0);
		`CHK("no visibility", 1'h0, internal_bus_visible)
		wr(8'h70);
		`CHK("first ignored", 4'h0, {mode_bits, ext_bus_wide, bus_stop_in_wait})
		wr(8'h70);
		wr(8'h54);
		`CHK("to wide", 4'he, {mode_bits, ext_bus_wide, bus_stop_in_wait})
		rd(16'h000b, 8'h70);
		wr(8'hf8);
		`CHK("to normal", 2'h3, {special_select_low, internal_bus_visible})
		// peripheral: register absent and mode fixed
		rst(3'h2);
		wr(8'h00);
		`CHK("peri hold", 3'h5, {mode_bits, core_hold})
		rd(16'h000b, 8'h00);
		end_sim;
	end
endmodule // tb_top
